// ### hdl/oper_mode_defs.svh
`ifndef OPER_MODE_DEFS_SVH
`define OPER_MODE_DEFS_SVH

// ==========================================================
// register location on the serial register port
`define OPER_MODE_ADDR          7'h13

// ==========================================================
// field positions inside the operating mode register
`define HPF_BYPASS_BIT          0
`define LPF_BYPASS_BIT          1
`define PULSE_DISABLE_BIT       2
`define ADC_SEL_LSB             3
`define ADC_SEL_MSB             5
`define SW_RESET_BIT            6
`define RESERVED_BIT            7

// ==========================================================
// reset value (pulse outputs off, everything else clear) and the converter select codes
`define OPER_MODE_RESET         8'h04
`define ADC_SEL_NORMAL          3'h0
`define ADC_SEL_SWAP            3'h4
`define ADC_SEL_CUR_OFF         3'h1
`define ADC_SEL_CUR_OFF_REDIR   3'h5
`define ADC_SEL_VOLT_OFF        3'h2
`define ADC_SEL_VOLT_OFF_REDIR  3'h6
`define ADC_SEL_SLEEP           3'h3
`define ADC_SEL_POWER_DOWN      3'h7

// ==========================================================
// timing of the software reset sequence
`define CLK_PERIOD_NS           8
`define SW_RESET_QUIET_NS       18000
`define SW_RESET_QUIET_CYCLES   ((`SW_RESET_QUIET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SW_RESET_DRIVE_CYCLES   16
`define SW_RESET_CNT_W          12

`endif

// ### hdl/oper_mode_pkg.sv
package oper_mode_pkg;

   // ==========================================================
   // types shared by the mode register and its reset sequencer
   typedef logic [2:0] adc_field_type;
   typedef logic [7:0] reg_byte_type;
   typedef logic [6:0] reg_addr_type;

   typedef enum logic [1:0]
   {
      seq_idle,
      seq_drive,
      seq_quiet
   } reset_state_type;

endpackage

// ### hdl/reset_seq_if.sv
`timescale 1ns/1ns

// ==========================================================
// link between the mode register and the reset sequencer
interface reset_seq_if;
   logic start;
   logic busy;
   logic chip_reset;
   logic done;

   modport ctrl
   (
      output start,
      input  busy,
      input  chip_reset,
      input  done
   );

   modport seq
   (
      input  start,
      output busy,
      output chip_reset,
      output done
   );
endinterface

// ### hdl/soft_reset_sequencer.sv
`timescale 1ns/1ns
`include "oper_mode_defs.svh"

module soft_reset_sequencer
(
   input  wire logic   clk_sys,
   input  wire logic   arst_n,
   reset_seq_if.seq    seq_port
);
   import oper_mode_pkg::*;

   localparam logic [`SW_RESET_CNT_W-1:0] DRIVE_LAST =
      `SW_RESET_CNT_W'(`SW_RESET_DRIVE_CYCLES - 1);
   localparam logic [`SW_RESET_CNT_W-1:0] QUIET_LAST =
      `SW_RESET_CNT_W'(`SW_RESET_QUIET_CYCLES - 1);

   reset_state_type              state_reg;
   reset_state_type              state_next;
   logic [`SW_RESET_CNT_W-1:0]   count_reg;
   logic [`SW_RESET_CNT_W-1:0]   count_next;
   logic                         drive_end;
   logic                         quiet_end;

   // ==========================================================
   // window counting
   // the count runs across both phases so the whole quiet window is 18 us
   assign drive_end = (count_reg == DRIVE_LAST);
   assign quiet_end = (count_reg == QUIET_LAST);

   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      unique case (state_reg)
         seq_idle:
         begin
            count_next = '0;
            if (seq_port.start)
               state_next = seq_drive;
         end
         seq_drive:
         begin
            count_next = count_reg + 1'b1;
            if (drive_end)
               state_next = seq_quiet;
         end
         seq_quiet:
         begin
            count_next = count_reg + 1'b1;
            if (quiet_end)
               state_next = seq_idle;
         end
      endcase
   end

   // state and counter
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= seq_idle;
         count_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // ==========================================================
   // status toward the mode register
   assign seq_port.busy       = (state_reg != seq_idle);
   assign seq_port.chip_reset = (state_reg == seq_drive);
   assign seq_port.done       = (state_reg == seq_quiet) && quiet_end;

endmodule

// ### hdl/operating_mode_control_register.sv
`timescale 1ns/1ns
`include "oper_mode_defs.svh"

module operating_mode_control_register
(
   input  wire logic                   clk_sys,
   input  wire logic                   arst_n,
   input  wire logic                   reg_wr_en,
   input  wire logic                   reg_rd_en,
   input  wire oper_mode_pkg::reg_addr_type reg_addr,
   input  wire oper_mode_pkg::reg_byte_type reg_wr_data,
   output      oper_mode_pkg::reg_byte_type reg_rd_data,
   output      logic                   current_highpass_bypass,
   output      logic                   current_lowpass_bypass,
   output      logic                   pulse_outputs_disable,
   output      oper_mode_pkg::adc_field_type adc_shutdown_select,
   output      logic                   current_adc_off,
   output      logic                   voltage_adc_off,
   output      logic                   current_to_voltage_path,
   output      logic                   voltage_to_current_path,
   output      logic                   sleep_mode,
   output      logic                   power_down_mode,
   input  wire logic                   active_power_pulse_in,
   input  wire logic                   reactive_power_pulse_in,
   output      logic                   active_power_pulse_out,
   output      logic                   reactive_power_pulse_out,
   output      logic                   software_chip_reset,
   output      logic                   serial_hold_off
);
   import oper_mode_pkg::*;

   // ==========================================================
   // storage and register-port decode
   logic [5:0]       mode_reg;
   logic [5:0]       mode_next;
   logic             addr_hit;
   logic             mode_wr;
   reg_byte_type     read_view;
   reg_byte_type     rd_data_reg;
   reg_byte_type     rd_data_next;
   adc_field_type    adc_sel;

   reset_seq_if      seq_link ();

   soft_reset_sequencer u_reset_seq
   (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .seq_port (seq_link.seq)
   );

   // writes are dropped while the software reset window is open,
   // since the host is not meant to talk to us then anyway
   // one mapped address only; everything else on the port belongs to
   // other registers and is left to their own decoders
   assign addr_hit = (reg_addr == `OPER_MODE_ADDR);
   assign mode_wr  = reg_wr_en && addr_hit && !seq_link.busy;

   // ==========================================================
   // software reset request
   // only bit 6 of an accepted write starts the sequence; bit 7 is dropped
   assign seq_link.start = mode_wr && reg_wr_data[`SW_RESET_BIT];

   // the chip reset phase returns every field to default
   assign mode_next = seq_link.chip_reset ? 6'(`OPER_MODE_RESET)
                    : mode_wr ? reg_wr_data[5:0]
                    : mode_reg;

   // only the low six bits are stored; reset value puts pulse disable at one
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         mode_reg <= 6'(`OPER_MODE_RESET);
      else
         mode_reg <= mode_next;
   end

   // ==========================================================
   // read path
   // the reset bit reads one until the sequence completes, then self-clears;
   // reserved bit always reads zero
   assign read_view = {1'b0, seq_link.busy, mode_reg};
   // unmapped addresses read zero
   assign rd_data_next = (reg_rd_en && addr_hit) ? read_view
                       : reg_rd_en ? 8'h00
                       : rd_data_reg;

   // loads only on a read strobe, so a slow host may take the byte
   // any number of cycles later and still see the same value
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         rd_data_reg <= 8'h00;
      else
         rd_data_reg <= rd_data_next;
   end

   assign reg_rd_data = rd_data_reg;

   // ==========================================================
   // converter control field decode
   assign adc_sel = mode_reg[`ADC_SEL_MSB:`ADC_SEL_LSB];

   logic cur_off_next;
   logic volt_off_next;
   logic cur_to_volt_next;
   logic volt_to_cur_next;
   logic sleep_next;
   logic pdown_next;

   // sleep and power-down keep the converter flags low; those modes gate
   // the whole device, so the per-channel flags would only be noise
   assign cur_off_next     = (adc_sel == `ADC_SEL_CUR_OFF)
                          || (adc_sel == `ADC_SEL_CUR_OFF_REDIR);
   assign volt_off_next    = (adc_sel == `ADC_SEL_VOLT_OFF)
                          || (adc_sel == `ADC_SEL_VOLT_OFF_REDIR);
   assign cur_to_volt_next = (adc_sel == `ADC_SEL_CUR_OFF_REDIR)
                          || (adc_sel == `ADC_SEL_SWAP);
   assign volt_to_cur_next = (adc_sel == `ADC_SEL_VOLT_OFF_REDIR)
                          || (adc_sel == `ADC_SEL_SWAP);
   assign sleep_next       = (adc_sel == `ADC_SEL_SLEEP);
   assign pdown_next       = (adc_sel == `ADC_SEL_POWER_DOWN);

   // ==========================================================
   // registered control outputs
   logic hpf_reg;
   logic lpf_reg;
   logic cf_dis_reg;
   logic [2:0] sel_reg;
   logic cur_off_reg;
   logic volt_off_reg;
   logic c2v_reg;
   logic v2c_reg;
   logic sleep_reg;
   logic pdown_reg;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hpf_reg      <= 1'b0;
         lpf_reg      <= 1'b0;
         cf_dis_reg   <= 1'b1;
         sel_reg      <= `ADC_SEL_NORMAL;
         cur_off_reg  <= 1'b0;
         volt_off_reg <= 1'b0;
         c2v_reg      <= 1'b0;
         v2c_reg      <= 1'b0;
         sleep_reg    <= 1'b0;
         pdown_reg    <= 1'b0;
      end
      else
      begin
         hpf_reg      <= mode_reg[`HPF_BYPASS_BIT];
         lpf_reg      <= mode_reg[`LPF_BYPASS_BIT];
         cf_dis_reg   <= mode_reg[`PULSE_DISABLE_BIT];
         sel_reg      <= adc_sel;
         cur_off_reg  <= cur_off_next;
         volt_off_reg <= volt_off_next;
         c2v_reg      <= cur_to_volt_next;
         v2c_reg      <= volt_to_cur_next;
         sleep_reg    <= sleep_next;
         pdown_reg    <= pdown_next;
      end
   end

   assign current_highpass_bypass = hpf_reg;
   assign current_lowpass_bypass  = lpf_reg;
   assign pulse_outputs_disable   = cf_dis_reg;
   assign adc_shutdown_select     = sel_reg;
   assign current_adc_off         = cur_off_reg;
   assign voltage_adc_off         = volt_off_reg;
   assign current_to_voltage_path = c2v_reg;
   assign voltage_to_current_path = v2c_reg;
   assign sleep_mode              = sleep_reg;
   assign power_down_mode         = pdown_reg;

   // ==========================================================
   // pulse output gating
   // gated straight from the stored bit so a disable takes effect one
   // cycle after the write, with no half-pulse glitch on the pin
   logic ap_out_reg;
   logic rp_out_reg;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ap_out_reg <= 1'b0;
         rp_out_reg <= 1'b0;
      end
      else
      begin
         ap_out_reg <= active_power_pulse_in && !mode_reg[`PULSE_DISABLE_BIT];
         rp_out_reg <= reactive_power_pulse_in && !mode_reg[`PULSE_DISABLE_BIT];
      end
   end

   assign active_power_pulse_out   = ap_out_reg;
   assign reactive_power_pulse_out = rp_out_reg;

   // ==========================================================
   // reset outputs toward the rest of the chip
   // both come straight from sequencer state flops,
   // so neither can glitch while the window counter ripples
   assign software_chip_reset = seq_link.chip_reset;
   assign serial_hold_off     = seq_link.busy;

endmodule

// ### tb/operating_mode_control_register_properties.sv
`timescale 1ns/1ns
`include "oper_mode_defs.svh"

// ==========================================================
// port-level properties of the mode register
module operating_mode_control_register_properties
(
   input wire logic                          clk_sys,
   input wire logic                          arst_n,
   input wire logic                          reg_wr_en,
   input wire oper_mode_pkg::reg_addr_type   reg_addr,
   input wire oper_mode_pkg::reg_byte_type   reg_wr_data,
   input wire logic                          current_highpass_bypass,
   input wire logic                          pulse_outputs_disable,
   input wire oper_mode_pkg::adc_field_type  adc_shutdown_select,
   input wire logic                          current_adc_off,
   input wire logic                          sleep_mode,
   input wire logic                          power_down_mode,
   input wire logic                          active_power_pulse_in,
   input wire logic                          active_power_pulse_out,
   input wire logic                          software_chip_reset,
   input wire logic                          serial_hold_off
);
   import oper_mode_pkg::*;
   logic [11:0] hold_cnt_reg;
   wire         wr_ok;

   // accepted write to the mode register
   assign wr_ok = reg_wr_en && reg_addr == `OPER_MODE_ADDR && !serial_hold_off;

   // hold-off length counter; a delay chain of 2250 would crawl
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         hold_cnt_reg <= 12'h000;
      else if (serial_hold_off)
         hold_cnt_reg <= hold_cnt_reg + 12'h001;
      else
         hold_cnt_reg <= 12'h000;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // properties
   property p_hpf;
      wr_ok && !reg_wr_data[6] |-> ##2 current_highpass_bypass == $past(reg_wr_data[0], 2);
   endproperty
   a_hpf: assert property (p_hpf) else $error("high-pass bypass not stored");
   property p_adc;
      wr_ok && !reg_wr_data[6] |-> ##2 adc_shutdown_select == $past(reg_wr_data[5:3], 2);
   endproperty
   a_adc: assert property (p_adc) else $error("converter field not stored");
   property p_cur;
      current_adc_off == (adc_shutdown_select inside {3'h1, 3'h5});
   endproperty
   a_cur: assert property (p_cur) else $error("current converter off wrong");
   property p_sleep;
      sleep_mode == (adc_shutdown_select == `ADC_SEL_SLEEP);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep decode wrong");
   property p_pdn;
      power_down_mode == (adc_shutdown_select == `ADC_SEL_POWER_DOWN);
   endproperty
   a_pdn: assert property (p_pdn) else $error("power-down decode wrong");
   property p_pulse;
      active_power_pulse_out |-> $past(active_power_pulse_in) && !pulse_outputs_disable;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse passed while gated");
   property p_software_chip_reset;
      wr_ok && reg_wr_data[6] |-> ##1 software_chip_reset && serial_hold_off
         ##15 software_chip_reset ##1 !software_chip_reset;
   endproperty
   a_software_chip_reset: assert property (p_software_chip_reset) else $error("chip reset pulse wrong");
   property p_hold;
      $fell(serial_hold_off) |-> hold_cnt_reg == 12'h8CA;
   endproperty
   a_hold: assert property (p_hold) else $error("hold-off span wrong");
endmodule

bind operating_mode_control_register operating_mode_control_register_properties u_props
(
   .clk_sys, .arst_n, .reg_wr_en, .reg_addr, .reg_wr_data, .current_highpass_bypass,
   .pulse_outputs_disable, .adc_shutdown_select, .current_adc_off, .sleep_mode,
   .power_down_mode, .active_power_pulse_in, .active_power_pulse_out,
   .software_chip_reset, .serial_hold_off
);

// ### tb/mode_host_model.sv
`timescale 1ns/1ns

// ==========================================================
// host side of the register port
module mode_host_model
(
   input  wire logic                        clk_sys,
   input  wire logic                        serial_hold_off,
   input  wire oper_mode_pkg::reg_byte_type reg_rd_data,
   output      logic                        reg_wr_en,
   output      logic                        reg_rd_en,
   output      oper_mode_pkg::reg_addr_type reg_addr,
   output      oper_mode_pkg::reg_byte_type reg_wr_data
);
   import oper_mode_pkg::*;

   // idle port at time zero
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 7'h00;
      reg_wr_data = 8'h00;
   end

   // one write; a polite host waits out the quiet window
   task automatic wr(input reg_addr_type a, input reg_byte_type d, input bit polite);
      @(posedge clk_sys);
      #1;
      while (polite && serial_hold_off)
      begin
         @(posedge clk_sys);
         #1;
      end
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wr_data = polite ? {1'b0, d[6:0]} : d;
      @(posedge clk_sys);
      #1;
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~reg_wr_data;
      // hold-off rises at the edge that takes the write; a polite reset write still waits here three edges
      if (d[6] && polite)
      begin
         repeat (3) @(posedge clk_sys);
         #1;
      end
   endtask

   // one read, data taken a cycle after the strobe
   task automatic rd(input reg_addr_type a, output reg_byte_type d);
      @(posedge clk_sys);
      #1;
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(posedge clk_sys);
      #1;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      @(posedge clk_sys);
      #1;
      d = reg_rd_data;
   endtask
endmodule

// ### tb/operating_mode_control_register_bench.sv
`timescale 1ns/1ns
`include "oper_mode_defs.svh"

module operating_mode_control_register_bench;
   import oper_mode_pkg::*;
   logic          clk_sys, arst_n, wr_en, rd_en, api, rpi;
   reg_addr_type  addr;
   reg_byte_type  wdata, rdata, rd_val;
   adc_field_type adc;
   logic          hpf, lpf, dis, cur, volt, c2v, v2c, slp, pd, apo, rpo, scr, hold;
   int            n_fail, n_tests, m, i;
   int            q[$];
   wire [15:0]    obs = {4'h0, hpf, lpf, dis, adc, cur, volt, c2v, v2c, slp, pd};

   operating_mode_control_register u_operating_mode_control_register
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
      .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata),
      .current_highpass_bypass(hpf), .current_lowpass_bypass(lpf),
      .pulse_outputs_disable(dis), .adc_shutdown_select(adc), .current_adc_off(cur),
      .voltage_adc_off(volt), .current_to_voltage_path(c2v),
      .voltage_to_current_path(v2c), .sleep_mode(slp), .power_down_mode(pd),
      .active_power_pulse_in(api), .reactive_power_pulse_in(rpi),
      .active_power_pulse_out(apo), .reactive_power_pulse_out(rpo),
      .software_chip_reset(scr), .serial_hold_off(hold)
   );

   mode_host_model host
   (
      .clk_sys(clk_sys), .serial_hold_off(hold), .reg_rd_data(rdata),
      .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata)
   );

   // ==========================================================
   // clock and watchdog
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial
   begin
      #200_000;
      n_fail++;
      end_sim;
   end

   // ==========================================================
   // model and checks
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // expected decoded outputs from the stored byte
   function automatic logic [15:0] expo(input int v);
      int c;
      c = (v >> 3) & 7;
      return {4'h0, v[0], v[1], v[2], c[2:0], c == 1 || c == 5, c == 2 || c == 6,
              c == 4 || c == 5, c == 4 || c == 6, c == 3, c == 7};
   endfunction

   task automatic check_all(input string what);
      host.rd(`OPER_MODE_ADDR, rd_val);
      chk(what, {8'h00, rd_val}, 16'(m));
      chk(what, obs, expo(m));
   endtask

   task automatic put(input int d, input bit polite);
      host.wr(`OPER_MODE_ADDR, 8'(d), polite);
      m = d & 8'h3F;
      check_all("mode");
   endtask

   // random pulses, passed a cycle late unless gated
   task automatic pulses(input bit off);
      logic a, r;
      repeat (8)
      begin
         a = 1'($urandom);
         r = 1'($urandom);
         @(posedge clk_sys);
         #1;
         api = a;
         rpi = r;
         @(posedge clk_sys);
         #1;
         chk("pulse", {14'h0, apo, rpo}, off ? 16'h0000 : {14'h0, a, r});
      end
   endtask

   task automatic end_sim;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      arst_n = 1'b0;
      api = 1'b0;
      rpi = 1'b0;
      n_fail = 0;
      n_tests = 0;
      m = 4;
      void'($urandom(28));
      repeat (2) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      check_all("reset");
      // every converter code with random low bits
      for (i = 0; i < 8; i++)
         q.push_back((i << 3) | ($urandom & 7));
      while (q.size() > 0)
         put(q.pop_front(), 1'b1);
      put(8'h00, 1'b1);
      pulses(1'b0);
      put(8'h04, 1'b1);
      pulses(1'b1);
      // reserved bit and unmapped address are dropped
      put(8'h83, 1'b0);
      host.wr(7'h14, 8'h3F, 1'b1);
      check_all("unmapped write");
      host.rd(7'h14, rd_val);
      chk("unmapped read", {8'h00, rd_val}, 16'h0000);
      // software reset, then a rude write inside the quiet window
      host.wr(`OPER_MODE_ADDR, 8'h5B, 1'b1);
      chk("reset seq", {14'h0, scr, hold}, 16'h0003);
      host.rd(`OPER_MODE_ADDR, rd_val);
      chk("busy read", {8'h00, rd_val}, 16'h0044);
      host.wr(`OPER_MODE_ADDR, 8'h01, 1'b0);
      m = 4;
      i = 0;
      while (hold && i < 3000)
      begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      chk("hold end", {15'h0, hold}, 16'h0000);
      check_all("after reset");
      end_sim;
   end
endmodule
